// File: verilog/boost_cfg_pkg.sv
// shared constants and types for the boost configuration register bank
package boost_cfg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int REG_COUNT = 4;
  localparam int unsigned FADE_TICK_NS = 10;

  localparam logic [7:0] CONVERTER_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] BOOST_LIMIT_FREQUENCY_ADDR = 8'h01;
  localparam logic [7:0] BRIGHTNESS_RAMP_RATE_ADDR = 8'h02;
  localparam logic [7:0] DIMMING_CONFIGURATION_ADDR = 8'h03;

  localparam logic [7:0] CONVERTER_CONTROL_RST = 8'hC2;
  localparam logic [7:0] BOOST_LIMIT_FREQUENCY_RST = 8'h4B;
  localparam logic [7:0] BRIGHTNESS_RAMP_RATE_RST = 8'h02;
  localparam logic [7:0] DIMMING_CONFIGURATION_RST = 8'h12;

  // field positions
  localparam int GAIN_LSB = 5;
  localparam int MODE_BIT = 4;
  localparam int OVP_LSB = 0;
  localparam int ILIM_LSB = 5;
  localparam int FSW_LSB = 0;
  localparam int FADE_LSB = 4;
  localparam int LOG_BIT = 6;
  localparam int MIX_BIT = 5;
  localparam int MAXI_LSB = 0;

  // writable masks; reserved bits keep what was loaded
  localparam logic [7:0] LIMIT_FREQ_WMASK = 8'h6F;
  localparam logic [7:0] RAMP_WMASK = 8'hF0;
  localparam logic [7:0] DIMCFG_WMASK = 8'h7F;

  // over-voltage threshold in millivolts, 0 for undocumented codes
  localparam int unsigned OVP_STEP_MV = 1875;
  localparam int unsigned OVP_TOP_MV = 43750;
  localparam int unsigned OVP_LOW_MV = 19375;

  typedef enum logic [1:0] {
    ILIM_2A0 = 2'h0,
    ILIM_1A0 = 2'h1,
    ILIM_2A5 = 2'h2,
    ILIM_3A0 = 2'h3
  } current_limit_e;

  typedef enum logic {
    SWITCH_DCM = 1'b0,
    SWITCH_FORCED_CCM = 1'b1
  } switch_mode_e;

  typedef struct packed {
    logic [2:0] loop_gain_select;
    switch_mode_e switch_mode;
    logic [3:0] overvoltage_threshold;
    current_limit_e switch_current_limit;
    logic [3:0] switching_frequency_select;
    logic [3:0] ramp_code;
    logic log_mapping;
    logic dimming_method_select;
    logic [4:0] max_current_code;
  } converter_cfg_s;

  typedef struct packed {
    logic [15:0] overvoltage_mv;
    logic [11:0] frequency_khz;
    logic [11:0] current_limit_ma;
    logic [3:0] gain_atten_db;
  } converter_decode_s;

  // step periods in ns indexed by ramp code; entry 0 means no fading
  localparam logic [31:0] RAMP_NS [16] = '{
    32'd0, 32'd44700, 32'd1432000, 32'd2148000,
    32'd2860000, 32'd3548000, 32'd4290000, 32'd5012000,
    32'd5700000, 32'd6440000, 32'd7100000, 32'd7800000,
    32'd8590000, 32'd9300000, 32'd10000000, 32'd10700000
  };

  localparam logic [11:0] FSW_KHZ [16] = '{
    12'd1430, 12'd1430, 12'd1430, 12'd953,
    12'd715, 12'd572, 12'd477, 12'd409,
    12'd358, 12'd318, 12'd286, 12'd260,
    12'd238, 12'd220, 12'd205, 12'd191
  };
endpackage : boost_cfg_pkg

// File: verilog/ramp_step_timer.sv
// fading step timer: one-cycle step pulses at the programmed interval
`timescale 1ns/1ps
module ramp_step_timer #(
  parameter int CLK_NS = 5,
  parameter int CNT_W = 24
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control
  input wire logic [3:0] ramp_code_in,
  // status
  output logic fading_on_out,
  output logic step_out
);
  import boost_cfg_pkg::*;

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] period;
  logic [3:0] last_code;

  initial begin
    if (CLK_NS < 1 || CNT_W < 22) begin
      $error("ramp_step_timer: counter too narrow for longest step");
    end
  end

  // cycles per step, rounded down so a step never comes late
  assign period = CNT_W'(RAMP_NS[ramp_code_in] / CLK_NS);
  assign fading_on_out = (ramp_code_in != 4'h0);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count <= '0;
      last_code <= 4'h0;
      step_out <= 1'b0;
    end else begin
      last_code <= ramp_code_in;
      step_out <= 1'b0;
      // restart on a new code so the old interval does not linger
      if (!fading_on_out || ramp_code_in != last_code) begin
        count <= '0;
      end else if (count >= period - CNT_W'(1)) begin
        count <= '0;
        step_out <= 1'b1;
      end else begin
        count <= count + CNT_W'(1);
      end
    end
  end
endmodule : ramp_step_timer

// File: verilog/backlight_boost_config_regs.sv
// configuration register bank of the backlight boost converter
`timescale 1ns/1ps
module backlight_boost_config_regs #(
  parameter int CLK_NS = 5
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // nonvolatile defaults, recalled at power-on
  input wire logic [boost_cfg_pkg::DATA_W*4-1:0] nonvolatile_defaults_in,
  input wire logic defaults_valid_in,
  // register port from the serial engine
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [boost_cfg_pkg::ADDR_W-1:0] addr_in,
  input wire logic [boost_cfg_pkg::DATA_W-1:0] wdata_in,
  output logic [boost_cfg_pkg::DATA_W-1:0] rdata_out,
  output logic addr_hit_out,
  // configuration towards the converter
  output boost_cfg_pkg::converter_cfg_s cfg_out,
  output boost_cfg_pkg::converter_decode_s decode_out,
  output logic fading_on_out,
  output logic ramp_step_out
);
  import boost_cfg_pkg::*;

  logic [7:0] regs [REG_COUNT];
  logic loaded;
  logic [3:0] ovp;

  function automatic logic hit(input logic [7:0] a);
    hit = (a < 8'(REG_COUNT));
  endfunction : hit

  function automatic logic [7:0] wmask(input logic [1:0] idx);
    unique case (idx)
      2'd0: wmask = 8'hFF;
      2'd1: wmask = LIMIT_FREQ_WMASK;
      2'd2: wmask = RAMP_WMASK;
      2'd3: wmask = DIMCFG_WMASK;
    endcase
  endfunction : wmask

  // host writes land in writable bits only; reserved bits hold defaults
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      regs[0] <= CONVERTER_CONTROL_RST;
      regs[1] <= BOOST_LIMIT_FREQUENCY_RST;
      regs[2] <= BRIGHTNESS_RAMP_RATE_RST;
      regs[3] <= DIMMING_CONFIGURATION_RST;
      loaded <= 1'b0;
    end else if (!loaded && defaults_valid_in) begin
      // recall happens once after release; the factory values stand until
      for (int i = 0; i < REG_COUNT; i++) begin
        regs[i] <= nonvolatile_defaults_in[i*8 +: 8];
      end
      loaded <= 1'b1;
    end else if (wr_en_in && hit(addr_in)) begin
      regs[addr_in[1:0]] <= (wdata_in & wmask(addr_in[1:0]))
                          | (regs[addr_in[1:0]] & ~wmask(addr_in[1:0]));
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_en_in) begin
      rdata_out <= hit(addr_in) ? regs[addr_in[1:0]] : 8'h00;
    end
  end

  assign addr_hit_out = hit(addr_in);

  // field extraction
  assign cfg_out.loop_gain_select = regs[0][GAIN_LSB +: 3];
  assign cfg_out.switch_mode = switch_mode_e'(regs[0][MODE_BIT]);
  assign cfg_out.overvoltage_threshold = regs[0][OVP_LSB +: 4];
  assign cfg_out.switch_current_limit =
    current_limit_e'(regs[1][ILIM_LSB +: 2]);
  assign cfg_out.switching_frequency_select = regs[1][FSW_LSB +: 4];
  assign cfg_out.ramp_code = regs[2][FADE_LSB +: 4];
  assign cfg_out.log_mapping = regs[3][LOG_BIT];
  assign cfg_out.dimming_method_select = regs[3][MIX_BIT];
  assign cfg_out.max_current_code = regs[3][MAXI_LSB +: 5];

  assign ovp = regs[0][OVP_LSB +: 4];

  // decoded values, registered so the converter sees clean levels
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      decode_out <= '0;
    end else begin
      // codes below 0010 are undocumented and decode as zero
      if (ovp == 4'hF) begin
        decode_out.overvoltage_mv <= 16'(OVP_LOW_MV);
      end else if (ovp >= 4'h2) begin
        decode_out.overvoltage_mv <=
          16'(OVP_TOP_MV - (32'(ovp) - 32'd2) * OVP_STEP_MV);
      end else begin
        decode_out.overvoltage_mv <= 16'h0000;
      end
      decode_out.frequency_khz <=
        FSW_KHZ[regs[1][FSW_LSB +: 4]];
      unique case (cfg_out.switch_current_limit)
        ILIM_2A0: decode_out.current_limit_ma <= 12'd2000;
        ILIM_1A0: decode_out.current_limit_ma <= 12'd1000;
        ILIM_2A5: decode_out.current_limit_ma <= 12'd2500;
        ILIM_3A0: decode_out.current_limit_ma <= 12'd3000;
      endcase
      // attenuation from the highest gain, two dB per code
      decode_out.gain_atten_db <=
        {cfg_out.loop_gain_select, 1'b0};
    end
  end

  ramp_step_timer #(
    .CLK_NS(CLK_NS),
    .CNT_W(24)
  ) u_ramp (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ramp_code_in(cfg_out.ramp_code),
    .fading_on_out(fading_on_out),
    .step_out(ramp_step_out)
  );
endmodule : backlight_boost_config_regs

// File: verif/boost_cfg_chk.sv
// assertions on the boost configuration register bank ports
`timescale 1ns/1ps
module boost_cfg_chk import boost_cfg_pkg::*; (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // register port
  input wire logic wr_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  // converter side
  input wire boost_cfg_pkg::converter_cfg_s cfg_out,
  input wire boost_cfg_pkg::converter_decode_s decode_out,
  input wire logic fading_on_out,
  input wire logic ramp_step_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire w0 = wr_en_in && addr_in == 8'h00;
  wire w3 = wr_en_in && addr_in == 8'h03;
  a_gain_write: assert property (w0 |=>
    cfg_out.loop_gain_select == $past(wdata_in[7:5])) else $error("gain");
  a_mode_write: assert property (w0 |=>
    cfg_out.switch_mode == $past(wdata_in[4])) else $error("mode");
  // decode is cleared on the release edge, so that edge starts no attempt
  a_ovp_top: assert property (!rst_in &&
    cfg_out.overvoltage_threshold == 4'h2 |=>
    decode_out.overvoltage_mv == 16'hAAE6) else $error("ovp");
  a_ilim_dec: assert property (!rst_in &&
    cfg_out.switch_current_limit == ILIM_2A5 |=>
    decode_out.current_limit_ma == 12'h9C4) else $error("ilim");
  a_fsw_top: assert property (!rst_in &&
    cfg_out.switching_frequency_select <= 4'h2 |=>
    decode_out.frequency_khz == 12'h596) else $error("fsw");
  a_step_flag: assert property (ramp_step_out |-> fading_on_out)
    else $error("step");
  a_log_write: assert property (w3 |=>
    cfg_out.log_mapping == $past(wdata_in[6])) else $error("log");
  a_mix_write: assert property (w3 |=>
    cfg_out.dimming_method_select == $past(wdata_in[5])) else $error("mix");
endmodule : boost_cfg_chk
bind backlight_boost_config_regs boost_cfg_chk i_chk (.clk_in, .rst_in,
  .wr_en_in, .addr_in, .wdata_in, .cfg_out, .decode_out, .fading_on_out,
  .ramp_step_out);

// File: verif/host_model.sv
// host model: single-byte register writes and reads
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic clk_in,
  // register port
  output logic wr_en_out = 1'b0,
  output logic rd_en_out = 1'b0,
  output logic [7:0] addr_out = 8'h00,
  output logic [7:0] wdata_out = 8'h00,
  input wire logic [7:0] rdata_in
);
  // the bench also hands in address 04, which selects no register
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_en_out <= 1'b1;
    addr_out <= a;
    wdata_out <= d;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    // released lines change so stale values never look valid
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    rd_en_out <= 1'b1;
    addr_out <= a;
    @(posedge clk_in);
    rd_en_out <= 1'b0;
    addr_out <= ~a;
    #1 d = rdata_in;
  endtask : rd
endmodule : host_model

// File: verif/test_backlight_boost_config_regs.sv
// self-checking bench for the boost configuration register bank
`timescale 1ns/1ps
module test_backlight_boost_config_regs;
  import boost_cfg_pkg::*;
  // defaults differ from factory values; reserved bits set on purpose
  localparam logic [31:0] NV = 32'h92359BE4;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wr_en, rd_en, fade_on, step, hit;
  logic [7:0] addr, wdata, rdata, got;
  converter_cfg_s cfg;
  converter_decode_s dec;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  // address, write data, expected read-back
  logic [23:0] rows [10] = '{24'h00FFFF, 24'h000404, 24'h01FFFF,
    24'h010090, 24'h02FFF5, 24'h020005, 24'h03FFFF, 24'h030080,
    24'h04AA00, 24'h001515};
  backlight_boost_config_regs i_dut (.clk_in(clk_in), .rst_in(rst_in),
    .nonvolatile_defaults_in(NV), .defaults_valid_in(1'b1),
    .wr_en_in(wr_en), .rd_en_in(rd_en), .addr_in(addr), .wdata_in(wdata),
    .rdata_out(rdata), .addr_hit_out(hit), .cfg_out(cfg), .decode_out(dec),
    .fading_on_out(fade_on), .ramp_step_out(step));
  host_model i_host (.clk_in(clk_in), .wr_en_out(wr_en), .rd_en_out(rd_en),
    .addr_out(addr), .wdata_out(wdata), .rdata_in(rdata));
  initial forever #2.5 clk_in = ~clk_in;
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // two fading intervals plus register traffic fit well below this
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    for (int i = 0; i < 4; i++) begin
      i_host.rd(8'(i), got);
      chk(16'(got), 16'(NV[8*i +: 8]));
    end
    $display("defaults done");
    foreach (rows[i]) begin
      i_host.wr(rows[i][23:16], rows[i][15:8]);
      i_host.rd(rows[i][23:16], got);
      chk(16'(got), 16'(rows[i][7:0]));
    end
    chk(dec.overvoltage_mv, 16'h94ED);
    $display("rows done");
    i_host.wr(8'h00, 8'h4F);
    i_host.wr(8'h01, 8'h60);
    repeat (2) @(posedge clk_in);
    #1 chk(dec.overvoltage_mv, 16'h4BAF);
    chk(16'(dec.current_limit_ma), 16'h0BB8);
    chk(16'(dec.frequency_khz), 16'h0596);
    chk(16'(dec.gain_atten_db), 16'h0004);
    chk(16'(hit), 16'h0000);
    $display("decode done");
    i_host.wr(8'h02, 8'h10);
    while (step !== 1'b1) begin
      @(posedge clk_in);
      #1;
    end
    n = 0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (step !== 1'b1);
    chk(16'(n), 16'h22EC);
    i_host.wr(8'h02, 8'h05);
    repeat (2) @(posedge clk_in);
    #1 chk(16'(fade_on), 16'h0000);
    $display("fading done");
    // a second reset must recall the stored defaults again
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    i_host.rd(8'h00, got);
    chk(16'(got), 16'h00E4);
    $display("reset done");
    summarize();
  end
endmodule : test_backlight_boost_config_regs
